// >>> verilog/efp_top.sv
// Purpose: Five edge flops with four-state outputs, evaluated each cycle.
// Assumes: All flop pins carry two-bit value codes synchronous to core_clk.
// Notes:   Asynchronous controls act at the next core_clk edge, since the
//          whole family is sampled; outputs are registered codes.
//
// Contract
// - Plain clock pin updates on rising edge
// - Inverted clock pin updates on falling edge
// - Rise loads data, Z/U loads U; fall holds
// - Clock to Z/U keeps value if data matches
// - Asserted set gives 1, asserted clear 0
// - Single-output: clear wins, unknown controls give U
// - Dual output flop; both asserted gives 1,1
// - Unknown control gives U,U; else data, complement
// - Strict dual flop: both asserted gives 0,0
// - Strict special cases beat the normal table
// - Releases within window d give U,U
// - Unknown set: 1,0 if prior 1, else U,U
// - Unknown clear, prior 0: gives 0,1
// - Unknown clear, prior not 0: gives U,0
// - Unknown set with asserted clear: 0,U
// - Enabled flop loads only while enable asserted; an unknown enable turns a change into U
`timescale 1ns/10ps
`default_nettype none

module efp_top
    import efp_pkg::*;
#(
    parameter bit CLK_INV_PLAIN  = 1'b0, // Plain flop clock marked inverted
    parameter bit CLK_INV_SC     = 1'b0, // Set/clear flop clock inverted
    parameter bit CLK_INV_DUAL   = 1'b0, // Dual flop clock inverted
    parameter bit CLK_INV_STRICT = 1'b0, // Strict flop clock inverted
    parameter bit CLK_INV_CE     = 1'b0, // Enabled flop clock inverted
    parameter int REL_WIN_NS     = 0,    // Strict release window, 0 = off
    parameter int WIN_CNT_W      = 8     // Release window counter width
) (
    input  wire logic     core_clk,        // Core clock, 25 MHz
    input  wire logic     rst_n,           // Async reset, active low
    // Plain flop
    input  wire efp_val_t pl_clk,          // Clock pin
    input  wire efp_val_t pl_data,         // Data pin
    output efp_val_t      pl_q,            // Output
    // set_clear_flop
    input  wire efp_val_t sc_clk,          // Clock pin
    input  wire efp_val_t sc_data,         // Data pin
    input  wire efp_val_t sc_async_set_n,  // Set, active low
    input  wire efp_val_t sc_async_clear_n,// Clear, active low
    output efp_val_t      sc_q,            // Output
    // dual_output_flop
    input  wire efp_val_t do_clk,          // Clock pin
    input  wire efp_val_t do_data,         // Data pin
    input  wire efp_val_t do_async_set_n,  // Set, active low
    input  wire efp_val_t do_async_clear_n,// Clear, active low
    output efp_val_t      do_q,            // True output
    output efp_val_t      do_q_n,          // Inverted output
    // strict_dual_output_flop
    input  wire efp_val_t sd_clk,          // Clock pin
    input  wire efp_val_t sd_data,         // Data pin
    input  wire efp_val_t sd_async_set_n,  // Set, active low
    input  wire efp_val_t sd_async_clear_n,// Clear, active low
    output efp_val_t      sd_q,            // True output
    output efp_val_t      sd_q_n,          // Inverted output
    // Clock-enabled flop
    input  wire efp_val_t ce_clk,          // Clock pin
    input  wire efp_val_t ce_data,         // Data pin
    input  wire efp_val_t ce_enable,       // Clock enable, active high
    output efp_val_t      ce_q             // Output
);

    // Window in cycles, rounded down as a longest time, at least one
    localparam int REL_WIN_RAW = REL_WIN_NS / EFP_CLK_PERIOD_NS;
    localparam int REL_WIN_CYC = (REL_WIN_RAW < 1) ? 1 : REL_WIN_RAW;
    localparam logic [WIN_CNT_W-1:0] WIN_LIMIT =
        WIN_CNT_W'(REL_WIN_CYC);
    localparam logic [WIN_CNT_W-1:0] WIN_MAX = {WIN_CNT_W{1'b1}};
    localparam logic [WIN_CNT_W-1:0] WIN_ONE = WIN_CNT_W'(1);
    localparam bit   WIN_ON = (REL_WIN_NS > 0);

    // Only a clean 0 asserts an active-low control; Z and U are
    // handled by the unknown branches of each flop instead
    function automatic logic ctl_on(input efp_val_t v);
        ctl_on = (v == EFP_V0);
    endfunction

    // Clean 0 to 1 step of a sampled active-low control; U to 1 is
    // not a release, as the control was never firmly asserted
    function automatic logic ctl_release(input efp_val_t was,
                                         input efp_val_t now);
        ctl_release = (was == EFP_V0) && (now == EFP_V1);
    endfunction

    // Cycles since the last release. Parks at zero until the first one
    // and saturates, so a stale release never wraps back into the window
    function automatic logic [WIN_CNT_W-1:0] since_step(
        input logic                 rel,
        input logic [WIN_CNT_W-1:0] cnt
    );
        if (rel) begin
            since_step = WIN_ONE;
        end else if (cnt == '0 || cnt == WIN_MAX) begin
            since_step = cnt;
        end else begin
            since_step = cnt + WIN_ONE;
        end
    endfunction

    // A count of zero means no release seen yet, never an overlap
    function automatic logic in_window(input logic [WIN_CNT_W-1:0] cnt);
        in_window = (cnt != '0) && (cnt <= WIN_LIMIT);
    endfunction

    // Edge detectors, one per flop
    logic pl_rise, pl_fall, pl_unk;
    logic sc_rise, sc_fall, sc_unk;
    logic do_rise, do_fall, do_unk;
    logic sd_rise, sd_fall, sd_unk;
    logic ce_rise, ce_fall, ce_unk;

    efp_edge #(.INVERT(CLK_INV_PLAIN)) u_pl_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_in   (pl_clk),
        .rise     (pl_rise),
        .fall     (pl_fall),
        .to_unk   (pl_unk)
    );
    efp_edge #(.INVERT(CLK_INV_SC)) u_sc_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_in   (sc_clk),
        .rise     (sc_rise),
        .fall     (sc_fall),
        .to_unk   (sc_unk)
    );
    efp_edge #(.INVERT(CLK_INV_DUAL)) u_do_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_in   (do_clk),
        .rise     (do_rise),
        .fall     (do_fall),
        .to_unk   (do_unk)
    );
    efp_edge #(.INVERT(CLK_INV_STRICT)) u_sd_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_in   (sd_clk),
        .rise     (sd_rise),
        .fall     (sd_fall),
        .to_unk   (sd_unk)
    );
    efp_edge #(.INVERT(CLK_INV_CE)) u_ce_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_in   (ce_clk),
        .rise     (ce_rise),
        .fall     (ce_fall),
        .to_unk   (ce_unk)
    );

    // Opposite edges change nothing; kept only to make the hold explicit
    logic any_fall;
    assign any_fall = pl_fall | sc_fall | do_fall | sd_fall | ce_fall;

    // Plain flop
    efp_val_t next_pl_q;
    // Fall and steady clocks hold; only rise and moves into Z/U act
    assign next_pl_q = efp_clocked(pl_q, pl_data,
                                   pl_rise, pl_unk);

    // Single-output set/clear flop, clear checked first
    logic     sc_set_on;
    logic     sc_clr_on;
    efp_val_t sc_clocked;
    efp_val_t next_sc_q;
    assign sc_set_on  = ctl_on(sc_async_set_n);
    assign sc_clr_on  = ctl_on(sc_async_clear_n);
    assign sc_clocked = efp_clocked(sc_q, sc_data, sc_rise, sc_unk);
    assign next_sc_q =
        efp_is_x(sc_async_clear_n)     ? EFP_VU :
        sc_clr_on                      ? EFP_V0 :
        efp_is_x(sc_async_set_n)       ? EFP_VU :
        sc_set_on                      ? EFP_V1 :
                                         sc_clocked;

    // Dual output flop
    logic     do_set_on;
    logic     do_clr_on;
    efp_val_t do_clocked;
    efp_val_t next_do_q;
    efp_val_t next_do_q_n;
    assign do_set_on  = ctl_on(do_async_set_n);
    assign do_clr_on  = ctl_on(do_async_clear_n);
    assign do_clocked = efp_clocked(do_q, do_data, do_rise, do_unk);

    always_comb begin
        if (efp_is_x(do_async_set_n) || efp_is_x(do_async_clear_n)) begin
            next_do_q   = EFP_VU;
            next_do_q_n = EFP_VU;
        end else if (do_set_on && do_clr_on) begin
            next_do_q   = EFP_V1;
            next_do_q_n = EFP_V1;
        end else if (do_set_on) begin
            next_do_q   = EFP_V1;
            next_do_q_n = EFP_V0;
        end else if (do_clr_on) begin
            next_do_q   = EFP_V0;
            next_do_q_n = EFP_V1;
        end else if (do_rise || do_unk) begin
            next_do_q   = do_clocked;
            next_do_q_n = efp_inv(do_clocked);
        end else begin
            next_do_q   = do_q;
            next_do_q_n = do_q_n;
        end
    end

    // Strict dual flop: release tracking for the overlap window
    efp_val_t             sd_prev_set;
    efp_val_t             sd_prev_clr;
    logic [WIN_CNT_W-1:0] sd_since_set;
    logic [WIN_CNT_W-1:0] sd_since_clr;
    logic                 sd_set_rel;
    logic                 sd_clr_rel;
    logic                 sd_overlap;
    logic [WIN_CNT_W-1:0] next_since_set;
    logic [WIN_CNT_W-1:0] next_since_clr;

    assign sd_set_rel = ctl_release(sd_prev_set, sd_async_set_n);
    assign sd_clr_rel = ctl_release(sd_prev_clr, sd_async_clear_n);
    // Releases in one cycle, or the second inside the first's window
    assign sd_overlap = WIN_ON &&
        ((sd_set_rel && sd_clr_rel) ||
         (sd_set_rel && in_window(sd_since_clr)) ||
         (sd_clr_rel && in_window(sd_since_set)));
    assign next_since_set = since_step(sd_set_rel, sd_since_set);
    assign next_since_clr = since_step(sd_clr_rel, sd_since_clr);

    logic     sd_set_on;
    logic     sd_clr_on;
    efp_val_t sd_clocked;
    efp_val_t next_sd_q;
    efp_val_t next_sd_q_n;
    assign sd_set_on  = ctl_on(sd_async_set_n);
    assign sd_clr_on  = ctl_on(sd_async_clear_n);
    assign sd_clocked = efp_clocked(sd_q, sd_data, sd_rise, sd_unk);

    // Special cases sit above the table; Z on a control counts as U
    always_comb begin
        if (sd_overlap) begin
            next_sd_q   = EFP_VU;
            next_sd_q_n = EFP_VU;
        end else if (efp_is_x(sd_async_set_n) && sd_clr_on) begin
            next_sd_q   = EFP_V0;
            next_sd_q_n = EFP_VU;
        end else if (efp_is_x(sd_async_set_n)) begin
            if (sd_q == EFP_V1) begin
                next_sd_q   = EFP_V1;
                next_sd_q_n = EFP_V0;
            end else begin
                next_sd_q   = EFP_VU;
                next_sd_q_n = EFP_VU;
            end
        end else if (efp_is_x(sd_async_clear_n)) begin
            if (sd_q == EFP_V0) begin
                next_sd_q   = EFP_V0;
                next_sd_q_n = EFP_V1;
            end else begin
                next_sd_q   = EFP_VU;
                next_sd_q_n = EFP_V0;
            end
        end else if (sd_set_on && sd_clr_on) begin
            next_sd_q   = EFP_V0;
            next_sd_q_n = EFP_V0;
        end else if (sd_set_on) begin
            next_sd_q   = EFP_V1;
            next_sd_q_n = EFP_V0;
        end else if (sd_clr_on) begin
            next_sd_q   = EFP_V0;
            next_sd_q_n = EFP_V1;
        end else if (sd_rise || sd_unk) begin
            next_sd_q   = sd_clocked;
            next_sd_q_n = efp_inv(sd_clocked);
        end else begin
            next_sd_q   = sd_q;
            next_sd_q_n = sd_q_n;
        end
    end

    // Clock-enabled flop; an unknown enable on an edge only keeps a
    // value the edge would not have changed
    logic     ce_on;
    logic     ce_unknown;
    efp_val_t ce_clocked;
    efp_val_t next_ce_q;
    assign ce_on      = (ce_enable == EFP_V1);
    assign ce_unknown = efp_is_x(ce_enable);
    assign ce_clocked = efp_clocked(ce_q, ce_data, ce_rise, ce_unk);
    assign next_ce_q =
        ce_on      ? ce_clocked :
        ce_unknown ? ((ce_clocked == ce_q) ? ce_q : EFP_VU) :
                     ce_q;

    // Every output is a register holding a full four-state code
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pl_q   <= EFP_RESET_Q;
            sc_q   <= EFP_RESET_Q;
            do_q   <= EFP_RESET_Q;
            do_q_n <= EFP_RESET_Q;
            sd_q   <= EFP_RESET_Q;
            sd_q_n <= EFP_RESET_Q;
            ce_q   <= EFP_RESET_Q;
        end else begin
            pl_q   <= any_fall ? next_pl_q : next_pl_q;
            sc_q   <= next_sc_q;
            do_q   <= next_do_q;
            do_q_n <= next_do_q_n;
            sd_q   <= next_sd_q;
            sd_q_n <= next_sd_q_n;
            ce_q   <= next_ce_q;
        end
    end

    // Release history; idle controls read as released
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_prev_set  <= EFP_V1;
            sd_prev_clr  <= EFP_V1;
            sd_since_set <= '0;
            sd_since_clr <= '0;
        end else begin
            sd_prev_set  <= sd_async_set_n;
            sd_prev_clr  <= sd_async_clear_n;
            sd_since_set <= next_since_set;
            sd_since_clr <= next_since_clr;
        end
    end

endmodule

`default_nettype wire

// >>> include/efp_pkg.sv
// Purpose: Shared encodings and value helpers for the edge flop family.
// Assumes: Four-state values travel as two-bit codes, one code per pin.
// Notes:   Z and U are distinct codes; loads turn Z into U, holds keep it.
package efp_pkg;

    // Four-state value carried on two wires
    typedef logic [1:0] efp_val_t;

    localparam efp_val_t EFP_V0 = 2'h0;
    localparam efp_val_t EFP_V1 = 2'h1;
    localparam efp_val_t EFP_VZ = 2'h2;
    localparam efp_val_t EFP_VU = 2'h3;

    // Power-up content of every flop
    localparam efp_val_t EFP_RESET_Q = EFP_VU;

    // Core clock period, used to turn nanosecond windows into cycles
    localparam int EFP_CLK_PERIOD_NS = 40;

    // True for Z or U
    function automatic logic efp_is_x(input efp_val_t v);
        efp_is_x = v[1];
    endfunction

    // Loaded value: 0 and 1 pass, Z and U become U
    function automatic efp_val_t efp_hard(input efp_val_t v);
        efp_hard = v[1] ? EFP_VU : v;
    endfunction

    // Logical complement; Z and U invert to U
    function automatic efp_val_t efp_inv(input efp_val_t v);
        efp_inv = v[1] ? EFP_VU : {1'b0, ~v[0]};
    endfunction

    // Clocked part shared by every variant
    function automatic efp_val_t efp_clocked(input efp_val_t q,
                                             input efp_val_t d,
                                             input logic     rise,
                                             input logic     to_unk);
        if (rise) begin
            efp_clocked = efp_hard(d);
        end else if (to_unk) begin
            efp_clocked = (d == q) ? q : EFP_VU;
        end else begin
            efp_clocked = q;
        end
    endfunction

endpackage

// >>> verilog/efp_edge.sv
// Purpose: Classifies the transitions of one sampled four-state clock pin.
// Assumes: The pin is synchronous to core_clk and sampled once per cycle.
// Notes:   Edge flags are combinational from the held previous sample.
`timescale 1ns/10ps
`default_nettype none

module efp_edge
    import efp_pkg::*;
#(
    parameter bit INVERT = 1'b0
) (
    input  wire logic     core_clk, // Core clock
    input  wire logic     rst_n,    // Async reset, active low
    input  wire efp_val_t clk_in,   // Sampled flop clock pin
    output logic          rise,     // Active edge this cycle
    output logic          fall,     // Opposite edge this cycle
    output logic          to_unk    // Clock moved into Z or U
);

    // Reset to the idle pin level seen through the inversion, so a
    // pin resting low never reads as an edge on the first cycle
    localparam efp_val_t IDLE_SEEN = INVERT ? EFP_V1 : EFP_V0;

    efp_val_t seen;
    efp_val_t prev;

    // A marked pin swaps the edges; Z and U stay unknown
    assign seen = INVERT ? efp_inv(clk_in) : clk_in;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= IDLE_SEEN;
        end else begin
            prev <= seen;
        end
    end

    assign rise   = (prev == EFP_V0) && (seen == EFP_V1);
    assign fall   = (prev == EFP_V1) && (seen == EFP_V0);
    assign to_unk = efp_is_x(seen) && (seen != prev);

endmodule

`default_nettype wire

// >>> tb/efp_top_checker.sv
// Purpose: Concurrent checks on the edge flop family outputs.
// Assumes: Pins are sampled on core_clk; outputs answer one cycle later.
// Notes:   Plain load and hold checks and the dual load check apply only to uninverted clock pins.
`timescale 1ns/10ps
`default_nettype none

module efp_top_checker
    import efp_pkg::*;
#(
    parameter bit CLK_INV_PLAIN = 1'b0, // Plain flop clock inverted
    parameter bit CLK_INV_DUAL  = 1'b0, // Dual flop clock inverted
    parameter int REL_WIN_NS    = 0     // Strict release window
) (
    input wire logic     core_clk,                    // Core clock
    input wire logic     rst_n,                       // Reset, active low
    input wire efp_val_t pl_clk, pl_data, pl_q,       // Plain flop
    input wire efp_val_t sc_async_set_n, sc_async_clear_n, sc_q, // Set/clear
    input wire efp_val_t do_clk, do_data, do_q, do_q_n, // Dual flop
    input wire efp_val_t do_async_set_n, do_async_clear_n, // Dual controls
    input wire efp_val_t sd_async_set_n, sd_async_clear_n, // Strict controls
    input wire efp_val_t sd_q, sd_q_n,                // Strict outputs
    input wire efp_val_t ce_enable, ce_q              // Enabled flop
);
    localparam int WIN_RAW = REL_WIN_NS / EFP_CLK_PERIOD_NS;
    localparam int WIN_CYC = (WIN_RAW < 1) ? 1 : WIN_RAW;
    localparam bit WIN_ON  = (REL_WIN_NS > 0);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence pl_rise;
        !CLK_INV_PLAIN && $past(pl_clk) == EFP_V0 && pl_clk == EFP_V1;
    endsequence
    // Window check is off when no window is configured
    sequence sd_set_rel;
        WIN_ON && $past(sd_async_set_n) == EFP_V0 && sd_async_set_n == EFP_V1;
    endsequence
    sequence sd_clr_rel;
        WIN_ON && $past(sd_async_clear_n) == EFP_V0
            && sd_async_clear_n == EFP_V1;
    endsequence

    plain_load_a: assert property (
        pl_rise |=> pl_q == ($past(pl_data[1]) ? EFP_VU : $past(pl_data)))
        else $error("plain flop missed its rising edge load");
    plain_hold_a: assert property (
        !CLK_INV_PLAIN && $past(pl_clk) == EFP_V1 && pl_clk == EFP_V0
            |=> $stable(pl_q))
        else $error("plain flop changed on its opposite edge");
    plain_unk_a: assert property (
        pl_clk[1] && !$past(pl_clk[1]) && pl_data != pl_q |=> pl_q == EFP_VU)
        else $error("plain flop kept value on unknown clock");
    sc_clear_a: assert property (
        sc_async_clear_n == EFP_V0 |=> sc_q == EFP_V0)
        else $error("set/clear flop ignored clear");
    sc_set_a: assert property (
        sc_async_set_n == EFP_V0 && sc_async_clear_n == EFP_V1
            |=> sc_q == EFP_V1)
        else $error("set/clear flop ignored set");
    dual_both_a: assert property (
        do_async_set_n == EFP_V0 && do_async_clear_n == EFP_V0
            |=> do_q == EFP_V1 && do_q_n == EFP_V1)
        else $error("dual flop wrong with both controls asserted");
    dual_unk_a: assert property (
        do_async_set_n[1] || do_async_clear_n[1]
            |=> do_q == EFP_VU && do_q_n == EFP_VU)
        else $error("dual flop wrong with unknown control");
    dual_load_a: assert property (
        !CLK_INV_DUAL && do_async_set_n == EFP_V1
            && do_async_clear_n == EFP_V1 && $past(do_clk) == EFP_V0
            && do_clk == EFP_V1 && !do_data[1]
            |=> do_q == $past(do_data)
                && do_q_n == {1'b0, ~$past(do_data[0])})
        else $error("dual flop load or complement wrong");
    strict_both_a: assert property (
        sd_async_set_n == EFP_V0 && sd_async_clear_n == EFP_V0
            |=> sd_q == EFP_V0 && sd_q_n == EFP_V0)
        else $error("strict flop wrong with both controls asserted");
    strict_setu_a: assert property (
        sd_async_set_n[1] && sd_async_clear_n == EFP_V0
            |=> sd_q == EFP_V0 && sd_q_n == EFP_VU)
        else $error("strict flop wrong with unknown set and clear");
    strict_same_a: assert property (
        (sd_set_rel and sd_clr_rel) |=> sd_q == EFP_VU && sd_q_n == EFP_VU)
        else $error("strict flop missed same cycle release");
    strict_late_a: assert property (
        sd_set_rel ##[1:WIN_CYC] sd_clr_rel
            |=> sd_q == EFP_VU && sd_q_n == EFP_VU)
        else $error("strict flop missed release inside window");
    ce_hold_a: assert property (
        ce_enable == EFP_V0 |=> $stable(ce_q))
        else $error("enabled flop changed while disabled");
endmodule

bind efp_top efp_top_checker #(
    .CLK_INV_PLAIN(CLK_INV_PLAIN), .CLK_INV_DUAL(CLK_INV_DUAL),
    .REL_WIN_NS(REL_WIN_NS)
) u_efp_top_checker (
    .core_clk(core_clk), .rst_n(rst_n),
    .pl_clk(pl_clk), .pl_data(pl_data), .pl_q(pl_q),
    .sc_async_set_n(sc_async_set_n), .sc_async_clear_n(sc_async_clear_n),
    .sc_q(sc_q), .do_clk(do_clk), .do_data(do_data),
    .do_q(do_q), .do_q_n(do_q_n),
    .do_async_set_n(do_async_set_n), .do_async_clear_n(do_async_clear_n),
    .sd_async_set_n(sd_async_set_n), .sd_async_clear_n(sd_async_clear_n),
    .sd_q(sd_q), .sd_q_n(sd_q_n), .ce_enable(ce_enable), .ce_q(ce_q)
);

`default_nettype wire

// >>> tb/efp_top_tb.sv
// Purpose: Directed scenarios for the five edge flops.
// Assumes: Inputs change at falling core_clk; results read one cycle on.
// Notes:   Enabled flop runs inverted; strict window is 120 ns (3 cycles).
`timescale 1ns/10ps
`default_nettype none

module efp_top_tb;
    import efp_pkg::*;
    logic     core_clk = 1'b0;
    logic     rst_n;
    efp_val_t pl_clk, pl_data, pl_q;
    efp_val_t sc_clk, sc_data, sc_async_set_n, sc_async_clear_n, sc_q;
    efp_val_t do_clk, do_data, do_async_set_n, do_async_clear_n, do_q, do_q_n;
    efp_val_t sd_clk, sd_data, sd_async_set_n, sd_async_clear_n, sd_q, sd_q_n;
    efp_val_t ce_clk, ce_data, ce_enable, ce_q;
    int       bad_count = 0;
    int       num_checks = 0;

    always #20 core_clk = ~core_clk;

    efp_top #(.CLK_INV_CE(1'b1), .REL_WIN_NS(120)) u_efp_top (
        .core_clk(core_clk), .rst_n(rst_n),
        .pl_clk(pl_clk), .pl_data(pl_data), .pl_q(pl_q),
        .sc_clk(sc_clk), .sc_data(sc_data), .sc_async_set_n(sc_async_set_n),
        .sc_async_clear_n(sc_async_clear_n), .sc_q(sc_q),
        .do_clk(do_clk), .do_data(do_data), .do_async_set_n(do_async_set_n),
        .do_async_clear_n(do_async_clear_n), .do_q(do_q), .do_q_n(do_q_n),
        .sd_clk(sd_clk), .sd_data(sd_data), .sd_async_set_n(sd_async_set_n),
        .sd_async_clear_n(sd_async_clear_n), .sd_q(sd_q), .sd_q_n(sd_q_n),
        .ce_clk(ce_clk), .ce_data(ce_data), .ce_enable(ce_enable),
        .ce_q(ce_q)
    );

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input efp_val_t exp,
                       input efp_val_t got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One rising core_clk samples the pins; read at the next falling edge
    task automatic step;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pl_try(input efp_val_t c, input efp_val_t d,
                          input efp_val_t e);
        pl_clk = c;
        pl_data = d;
        step();
        chk("pl_q", e, pl_q);
    endtask

    task automatic sc_try(input efp_val_t s, input efp_val_t c,
                          input efp_val_t e);
        sc_async_set_n = s;
        sc_async_clear_n = c;
        step();
        chk("sc_q", e, sc_q);
    endtask

    task automatic do_try(input efp_val_t s, input efp_val_t c,
                          input efp_val_t e, input efp_val_t en);
        do_async_set_n = s;
        do_async_clear_n = c;
        step();
        chk("do_q", e, do_q);
        chk("do_q_n", en, do_q_n);
    endtask

    task automatic sd_try(input efp_val_t s, input efp_val_t c,
                          input efp_val_t e, input efp_val_t en);
        sd_async_set_n = s;
        sd_async_clear_n = c;
        step();
        chk("sd_q", e, sd_q);
        chk("sd_q_n", en, sd_q_n);
    endtask

    task automatic ce_try(input efp_val_t en, input efp_val_t c,
                          input efp_val_t d, input efp_val_t e);
        ce_enable = en;
        ce_clk = c;
        ce_data = d;
        step();
        chk("ce_q", e, ce_q);
    endtask

    task automatic t_plain;
        pl_try(EFP_V1, EFP_V1, EFP_V1);
        pl_try(EFP_V0, EFP_V0, EFP_V1);
        pl_try(EFP_VU, EFP_V1, EFP_V1);
        pl_try(EFP_V0, EFP_V0, EFP_V1);
        pl_try(EFP_V1, EFP_VZ, EFP_VU);
        pl_try(EFP_V0, EFP_V0, EFP_VU);
        pl_try(EFP_V1, EFP_V0, EFP_V0);
        pl_try(EFP_VZ, EFP_V1, EFP_VU);
        $display("test plain done");
    endtask

    task automatic t_sc;
        sc_try(EFP_V0, EFP_V0, EFP_V0);
        sc_try(EFP_V0, EFP_V1, EFP_V1);
        sc_try(EFP_V0, EFP_VU, EFP_VU);
        sc_try(EFP_VZ, EFP_V1, EFP_VU);
        sc_clk = EFP_V1;
        sc_try(EFP_V1, EFP_V1, EFP_V0);
        $display("test set_clear done");
    endtask

    task automatic t_do;
        do_try(EFP_V0, EFP_V0, EFP_V1, EFP_V1);
        do_try(EFP_V0, EFP_V1, EFP_V1, EFP_V0);
        do_try(EFP_V1, EFP_V0, EFP_V0, EFP_V1);
        do_try(EFP_VZ, EFP_V1, EFP_VU, EFP_VU);
        do_try(EFP_V1, EFP_VU, EFP_VU, EFP_VU);
        do_data = EFP_V1;
        do_clk = EFP_V1;
        do_try(EFP_V1, EFP_V1, EFP_V1, EFP_V0);
        $display("test dual done");
    endtask

    task automatic t_sd;
        sd_try(EFP_V0, EFP_V0, EFP_V0, EFP_V0);
        sd_try(EFP_V0, EFP_V1, EFP_V1, EFP_V0);
        sd_try(EFP_VU, EFP_V1, EFP_V1, EFP_V0);
        sd_try(EFP_VU, EFP_V0, EFP_V0, EFP_VU);
        sd_try(EFP_V1, EFP_V0, EFP_V0, EFP_V1);
        sd_try(EFP_V1, EFP_VU, EFP_V0, EFP_V1);
        sd_try(EFP_V0, EFP_V1, EFP_V1, EFP_V0);
        sd_try(EFP_V1, EFP_VU, EFP_VU, EFP_V0);
        sd_try(EFP_VU, EFP_V1, EFP_VU, EFP_VU);
        sd_try(EFP_V0, EFP_V0, EFP_V0, EFP_V0);
        sd_try(EFP_V1, EFP_V1, EFP_VU, EFP_VU);
        // Spacing keeps earlier releases out of the next window
        repeat (4) sd_try(EFP_V0, EFP_V0, EFP_V0, EFP_V0);
        repeat (3) sd_try(EFP_V1, EFP_V0, EFP_V0, EFP_V1);
        sd_try(EFP_V1, EFP_V1, EFP_VU, EFP_VU);
        repeat (4) sd_try(EFP_V0, EFP_V0, EFP_V0, EFP_V0);
        repeat (4) sd_try(EFP_V1, EFP_V0, EFP_V0, EFP_V1);
        sd_try(EFP_V1, EFP_V1, EFP_V0, EFP_V1);
        sd_data = EFP_V1;
        sd_clk = EFP_V1;
        sd_try(EFP_V1, EFP_V1, EFP_V1, EFP_V0);
        $display("test strict done");
    endtask

    task automatic t_ce;
        ce_try(EFP_V1, EFP_V1, EFP_V1, EFP_RESET_Q);
        ce_try(EFP_V1, EFP_V0, EFP_V1, EFP_V1);
        ce_try(EFP_V0, EFP_V1, EFP_V0, EFP_V1);
        ce_try(EFP_V0, EFP_V0, EFP_V0, EFP_V1);
        ce_try(EFP_V1, EFP_V1, EFP_V0, EFP_V1);
        ce_try(EFP_V1, EFP_V0, EFP_V0, EFP_V0);
        ce_try(EFP_VU, EFP_V1, EFP_V1, EFP_V0);
        ce_try(EFP_VU, EFP_V0, EFP_V1, EFP_VU);
        $display("test enable done");
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        $display("BAD watchdog expected finish seen timeout");
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        {pl_clk, pl_data, sc_clk, sc_data, do_clk, do_data} = '0;
        {sd_clk, sd_data, ce_clk, ce_data, ce_enable} = '0;
        {sc_async_set_n, sc_async_clear_n} = {EFP_V1, EFP_V1};
        {do_async_set_n, do_async_clear_n} = {EFP_V1, EFP_V1};
        {sd_async_set_n, sd_async_clear_n} = {EFP_V1, EFP_V1};
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        step();
        chk("pl_q", EFP_RESET_Q, pl_q);
        t_plain();
        t_sc();
        t_do();
        t_sd();
        t_ce();
        end_of_test();
    end
endmodule

`default_nettype wire
